/* hw/cfg_prom_ctrl.sv */
// Start and reset control of the configuration memory.
// Assumes the target side keeps its own obligations on the shared link.
`timescale 1ns/1ns
`default_nettype none
`include "cfg_loader_defs.svh"

module cfg_prom_ctrl (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic jtag_config_cmd,
  input wire logic core_power_good,
  input wire logic io_power_good,
  input wire logic parallel_variant,
  input wire logic revisioning_enable,
  input wire logic external_select_enable,
  input wire logic [`REV_W-1:0] revision_choice_pins,
  input wire logic [`REV_W-1:0] internal_revision_bits,
  input wire logic clock_output_enable,
  output logic [`REV_W-1:0] active_revision,
  cfg_link_if.prom link
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] cfg_sync_q, core_sync_q, io_sync_q, rst_sync_q, ce_sync_q;
  logic [2:0] busy_sync_q;
  logic cfg_lvl_q, core_lvl_q, io_lvl_q, rstl_lvl_q, ce_lvl_q, busy_lvl_q;
  logic [2:0] cfg_sync_d, core_sync_d, io_sync_d, rst_sync_d, ce_sync_d;
  logic [2:0] busy_sync_d;
  logic cfg_lvl_d, core_lvl_d, io_lvl_d, rstl_lvl_d, ce_lvl_d, busy_lvl_d;

  function automatic logic settle(input logic [2:0] s, input logic old);
    settle = (s[1] == s[2]) ? s[2] : old;
  endfunction : settle

  always_comb begin
    cfg_sync_d = {cfg_sync_q[1:0], jtag_config_cmd};
    core_sync_d = {core_sync_q[1:0], core_power_good};
    io_sync_d = {io_sync_q[1:0], io_power_good};
    rst_sync_d = {rst_sync_q[1:0], link.reset_line_in};
    ce_sync_d = {ce_sync_q[1:0], link.chip_enable_n};
    busy_sync_d = {busy_sync_q[1:0], link.busy};
    cfg_lvl_d = settle(cfg_sync_q, cfg_lvl_q);
    core_lvl_d = settle(core_sync_q, core_lvl_q);
    io_lvl_d = settle(io_sync_q, io_lvl_q);
    rstl_lvl_d = settle(rst_sync_q, rstl_lvl_q);
    ce_lvl_d = settle(ce_sync_q, ce_lvl_q);
    busy_lvl_d = settle(busy_sync_q, busy_lvl_q);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_sync_q <= 3'h0;
      core_sync_q <= 3'h0;
      io_sync_q <= 3'h0;
      rst_sync_q <= 3'h0;
      ce_sync_q <= 3'h7;
      busy_sync_q <= 3'h0;
      cfg_lvl_q <= 1'b0;
      core_lvl_q <= 1'b0;
      io_lvl_q <= 1'b0;
      rstl_lvl_q <= 1'b0;
      ce_lvl_q <= 1'b1;
      busy_lvl_q <= 1'b0;
    end else begin
      cfg_sync_q <= cfg_sync_d;
      core_sync_q <= core_sync_d;
      io_sync_q <= io_sync_d;
      rst_sync_q <= rst_sync_d;
      ce_sync_q <= ce_sync_d;
      busy_sync_q <= busy_sync_d;
      cfg_lvl_q <= cfg_lvl_d;
      core_lvl_q <= core_lvl_d;
      io_lvl_q <= io_lvl_d;
      rstl_lvl_q <= rstl_lvl_d;
      ce_lvl_q <= ce_lvl_d;
      busy_lvl_q <= busy_lvl_d;
    end
  end

  // ****************************************
  // Power-on reset and release delay
  // ****************************************
  typedef enum logic [1:0] {PWR_OFF, PWR_WAIT, PWR_ON} pwr_state_type;
  pwr_state_type pwr_q, pwr_d;
  logic [15:0] rel_cnt_q, rel_cnt_d;
  logic hold_low_q, hold_low_d;
  logic supplies_ok;

  always_comb begin
    supplies_ok = core_lvl_q && (!parallel_variant || io_lvl_q);
    pwr_d = pwr_q;
    rel_cnt_d = rel_cnt_q;
    unique case (pwr_q)
      PWR_OFF: begin
        rel_cnt_d = 16'h0000;
        if (supplies_ok) pwr_d = PWR_WAIT;
      end
      PWR_WAIT: begin
        rel_cnt_d = rel_cnt_q + 16'h0001;
        if (rel_cnt_q >= 16'(`RELEASE_CYCLES - 1)) pwr_d = PWR_ON;
      end
      PWR_ON: ;
    endcase
    if (!core_lvl_q) pwr_d = PWR_OFF;
    hold_low_d = (pwr_d != PWR_ON);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pwr_q <= PWR_OFF;
      rel_cnt_q <= 16'h0000;
      hold_low_q <= 1'b1;
    end else begin
      pwr_q <= pwr_d;
      rel_cnt_q <= rel_cnt_d;
      hold_low_q <= hold_low_d;
    end
  end

  // ****************************************
  // Configure trigger and revision capture
  // ****************************************
  logic cfg_prev_q, trig_n_q, trig_n_d;
  logic [7:0] trig_cnt_q, trig_cnt_d;
  logic [`REV_W-1:0] rev_q, rev_d;

  always_comb begin
    trig_n_d = trig_n_q;
    trig_cnt_d = trig_cnt_q;
    rev_d = rev_q;
    if (!trig_n_q) begin
      trig_cnt_d = trig_cnt_q + 8'h01;
      if (trig_cnt_q >= 8'(`TRIG_CYCLES - 1)) begin
        trig_n_d = 1'b1;
        if (revisioning_enable)
          rev_d = external_select_enable ? revision_choice_pins
                                         : internal_revision_bits;
      end
    end else if (cfg_lvl_q && !cfg_prev_q && pwr_q == PWR_ON) begin
      trig_n_d = 1'b0;
      trig_cnt_d = 8'h00;
    end
    if (!revisioning_enable) rev_d = '0;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_prev_q <= 1'b0;
      trig_n_q <= 1'b1;
      trig_cnt_q <= 8'h00;
      rev_q <= '0;
    end else begin
      cfg_prev_q <= cfg_lvl_q;
      trig_n_q <= trig_n_d;
      trig_cnt_q <= trig_cnt_d;
      rev_q <= rev_d;
    end
  end

  // ****************************************
  // Address counter and outputs
  // ****************************************
  logic [`ADDR_W-1:0] addr_q, addr_d;
  logic ceo_n_q, ceo_n_d, oe_q, oe_d;
  logic [1:0] div_q, div_d;
  logic clk_q, clk_d, clk_prev_q, rise;
  logic clk_oe_q, clk_oe_d;
  logic in_reset;
  logic bank_end;

  function automatic logic [`ADDR_W-1:0] bank_base(input logic [1:0] r,
                                                   input logic en);
    bank_base = en ? (`ADDR_W'(r) << `BANK_SHIFT) : '0;
  endfunction : bank_base

  always_comb begin
    in_reset = !rstl_lvl_q || ce_lvl_q || pwr_q != PWR_ON;
    bank_end = revisioning_enable &&
      (addr_q == (bank_base(rev_q, 1'b1) | `ADDR_W'({`BANK_SHIFT{1'b1}})));
    div_d = div_q + 2'h1;
    clk_d = (div_q == 2'(`CLOCK_DIV - 1)) ? !clk_q : clk_q;
    rise = clk_q && !clk_prev_q;
    addr_d = addr_q;
    ceo_n_d = ceo_n_q;
    oe_d = oe_q;
    if (in_reset) begin
      addr_d = bank_base(rev_q, revisioning_enable);
      ceo_n_d = 1'b1;
      oe_d = 1'b0;
    end else begin
      // Last word of the selected bank: hold address, outputs off
      oe_d = ceo_n_q && !bank_end;
      if (rise && !busy_lvl_q && ceo_n_q && !bank_end) begin
        if (addr_q == {`ADDR_W{1'b1}}) begin
          ceo_n_d = 1'b0;
          oe_d = 1'b0;
        end else addr_d = addr_q + `ADDR_W'(1);
      end
    end
    clk_oe_d = clock_output_enable && oe_d;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      addr_q <= '0;
      ceo_n_q <= 1'b1;
      oe_q <= 1'b0;
      div_q <= 2'h0;
      clk_q <= 1'b0;
      clk_prev_q <= 1'b0;
      clk_oe_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      ceo_n_q <= ceo_n_d;
      oe_q <= oe_d;
      div_q <= div_d;
      clk_q <= clk_d;
      clk_prev_q <= clk_q;
      clk_oe_q <= clk_oe_d;
    end
  end

  always_comb begin
    link.config_trigger_out_n = trig_n_q;
    link.reset_line_drive_low = hold_low_q;
    link.chain_enable_out_n = ceo_n_q;
    link.data_out = addr_q[`DATA_W-1:0];
    link.data_oe = oe_q;
    link.prom_clock_output = clk_q;
    link.prom_clock_oe = clk_oe_q;
    active_revision = rev_q;
  end

endmodule : cfg_prom_ctrl

`default_nettype wire

/* hw/cfg_loader_defs.svh */
// Timing and layout constants for the configuration loader control pair.
// Assumes a 100 MHz system clock.
`ifndef CFG_LOADER_DEFS_SVH
`define CFG_LOADER_DEFS_SVH

`define CLK_PERIOD_NS 10
// Trigger pulse window, ns
`define TRIG_MIN_NS 300
`define TRIG_MAX_NS 500
// Aim at the middle of the window
`define TRIG_NS 400
`define TRIG_CYCLES ((`TRIG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Reset release delay after supplies good, ns
`define RELEASE_DELAY_NS 2000
`define RELEASE_CYCLES \
  ((`RELEASE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_W 16
`define REV_W 2
`define DATA_W 8
// Log2 of words per revision bank
`define BANK_SHIFT 14
// Target clears its memory for this many cycles after program
`define CLEAR_CYCLES 16
`define CLOCK_DIV 4

`endif

/* hw/cfg_loader_pkg.sv */
// Types shared by both ends of the configuration loader link.
// Assumes cfg_loader_defs.svh is on the include path.
`include "cfg_loader_defs.svh"

package cfg_loader_pkg;
  typedef logic [`ADDR_W-1:0] addr_type;
  typedef logic [`REV_W-1:0] rev_type;
  typedef logic [`DATA_W-1:0] data_type;
endpackage : cfg_loader_pkg

/* hw/cfg_link_if.sv */
// Link between the configuration memory and the target device.
// The open-drain reset/init wire is resolved inside this interface.
`timescale 1ns/1ns
`default_nettype none

interface cfg_link_if;
  logic config_trigger_out_n;
  logic reset_line_drive_low;
  logic init_drive_low;
  logic reset_line_in;
  logic chain_enable_out_n;
  logic chip_enable_n;
  cfg_loader_pkg::data_type data_out;
  logic data_oe;
  logic busy;
  logic prom_clock_output;
  logic prom_clock_oe;
  logic target_config_clock;
  logic target_read_write_n;
  logic target_chip_select_n;

  // Open-drain wire with pull-up
  assign reset_line_in = !(reset_line_drive_low || init_drive_low);

  modport prom (
    output config_trigger_out_n, reset_line_drive_low, chain_enable_out_n,
    output data_out, data_oe, prom_clock_output, prom_clock_oe,
    input reset_line_in, chip_enable_n, busy, target_config_clock
  );
  modport target (
    input config_trigger_out_n, reset_line_in, data_out, data_oe,
    input prom_clock_output, prom_clock_oe,
    output init_drive_low, chip_enable_n, busy, target_config_clock,
    output target_read_write_n, target_chip_select_n
  );
endinterface : cfg_link_if

`default_nettype wire

/* hw/cfg_target_end.sv */
// Target device end: program, init, busy and configuration clock.
// Assumes the memory end drives the trigger and data on the link.
`timescale 1ns/1ns
`default_nettype none
`include "cfg_loader_defs.svh"

module cfg_target_end (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hold_init_low,
  input wire logic busy_request,
  input wire logic done_level,
  output logic clearing,
  output logic ready_for_bitstream,
  cfg_link_if.target link
);

  typedef enum logic [1:0] {T_CLEAR, T_WAIT_INIT, T_LOAD} tgt_state_type;
  tgt_state_type st_q, st_d;
  logic [2:0] prog_sync_q, init_sync_q;
  logic prog_lvl_q, init_lvl_q, prog_lvl_d, init_lvl_d;
  logic [7:0] cnt_q, cnt_d;
  logic ext_clk_q;
  logic [1:0] div_q;

  always_comb begin
    prog_lvl_d = (prog_sync_q[1] == prog_sync_q[2]) ? prog_sync_q[2]
                                                    : prog_lvl_q;
    init_lvl_d = (init_sync_q[1] == init_sync_q[2]) ? init_sync_q[2]
                                                    : init_lvl_q;
    st_d = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      T_CLEAR: begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_q >= 8'(`CLEAR_CYCLES - 1)) st_d = T_WAIT_INIT;
      end
      T_WAIT_INIT: if (init_lvl_q) st_d = T_LOAD;
      T_LOAD: ;
    endcase
    if (!prog_lvl_q) begin
      st_d = T_CLEAR;
      cnt_d = 8'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prog_sync_q <= 3'h7;
      init_sync_q <= 3'h0;
      prog_lvl_q <= 1'b1;
      init_lvl_q <= 1'b0;
      st_q <= T_CLEAR;
      cnt_q <= 8'h00;
      div_q <= 2'h0;
      ext_clk_q <= 1'b0;
    end else begin
      prog_sync_q <= {prog_sync_q[1:0], link.config_trigger_out_n};
      init_sync_q <= {init_sync_q[1:0], link.reset_line_in};
      prog_lvl_q <= prog_lvl_d;
      init_lvl_q <= init_lvl_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) ext_clk_q <= !ext_clk_q;
    end
  end

  always_comb begin
    link.init_drive_low = (st_q == T_CLEAR) || hold_init_low;
    link.chip_enable_n = done_level;
    link.busy = busy_request && st_q == T_LOAD;
    // External clock only when memory clock is not driving
    link.target_config_clock = link.prom_clock_oe ? link.prom_clock_output
                                                  : ext_clk_q;
    link.target_read_write_n = 1'b0;
    link.target_chip_select_n = 1'b0;
    clearing = (st_q == T_CLEAR);
    ready_for_bitstream = (st_q == T_LOAD);
  end

endmodule : cfg_target_end

`default_nettype wire

/* testbench/cfg_link_checker.sv */
// Timing checks on the link between the memory end and the target end.
// Assumes all signals belong to the sys_clk domain.
`timescale 1ns/1ns
`default_nettype none
`include "cfg_loader_defs.svh"
module cfg_link_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic config_trigger_out_n,
  input wire logic reset_line_drive_low,
  input wire logic init_drive_low,
  input wire logic reset_line_in,
  input wire logic chain_enable_out_n,
  input wire logic chip_enable_n,
  input wire logic data_oe,
  input wire logic busy,
  input wire logic target_read_write_n,
  input wire logic target_chip_select_n,
  input wire cfg_loader_pkg::data_type data_out
);
  // ****
  // Cycle counters
  // ****
  logic [7:0] low_q, low_d, held_q, held_d;
  always_comb begin
    low_d = config_trigger_out_n ? 8'h00 : low_q + 8'h01;
    held_d = !reset_line_drive_low ? 8'h00 :
      ((held_q == 8'hFF) ? held_q : held_q + 8'h01);
  end
  always_ff @(posedge sys_clk) begin
    low_q <= rst_n ? low_d : 8'h00;
    held_q <= rst_n ? held_d : 8'h00;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_trig_width;
    $rose(config_trigger_out_n) |-> low_q == `TRIG_CYCLES;
  endproperty
  a_trig_width: assert property (p_trig_width)
    else $error("trigger low width wrong");
  property p_trig_powered;
    $fell(config_trigger_out_n) |-> !reset_line_drive_low;
  endproperty
  a_trig_powered: assert property (p_trig_powered)
    else $error("trigger while unpowered");
  property p_hold_reset;
    $rose(rst_n) |-> reset_line_drive_low [*8];
  endproperty
  a_hold_reset: assert property (p_hold_reset)
    else $error("reset line not held at power-up");
  property p_release_delay;
    $fell(reset_line_drive_low) |-> held_q >= `RELEASE_CYCLES;
  endproperty
  a_release_delay: assert property (p_release_delay)
    else $error("reset line released early");
  property p_reset_outputs;
    (!reset_line_in || chip_enable_n) [*6] |->
      chain_enable_out_n && !data_oe;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs)
    else $error("outputs active in reset");
  property p_target_init;
    $fell(config_trigger_out_n) |-> ##[1:100] init_drive_low;
  endproperty
  a_target_init: assert property (p_target_init)
    else $error("target did not hold init");
  property p_target_pins;
    !target_read_write_n && !target_chip_select_n;
  endproperty
  a_target_pins: assert property (p_target_pins)
    else $error("target select or write high");
  property p_busy_hold;
    (busy && data_oe) [*6] |-> $stable(data_out);
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("data moved while busy");
  c_trigger: cover property ($rose(config_trigger_out_n));
  c_stall: cover property ((busy && data_oe) [*3]);
  c_release: cover property ($fell(reset_line_drive_low));
endmodule : cfg_link_checker
`default_nettype wire

/* testbench/config_prom_start_and_reset_bench.sv */
// Bench of both loader ends joined by their link.
// Assumes the hw/ files and the link checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "cfg_loader_defs.svh"
module config_prom_start_and_reset_bench;
  logic sys_clk = 1'b0, rst_n = 1'b0, jtag_config_cmd = 1'b0;
  logic core_power_good = 1'b0, io_power_good = 1'b0;
  logic parallel_variant = 1'b1, revisioning_enable = 1'b0;
  logic external_select_enable = 1'b0, clock_output_enable = 1'b1;
  logic hold_init_low = 1'b0, busy_request = 1'b0, done_level = 1'b1;
  cfg_loader_pkg::rev_type revision_choice_pins = 2'h0;
  cfg_loader_pkg::rev_type internal_revision_bits = 2'h0;
  cfg_loader_pkg::rev_type active_revision, rev_exp;
  cfg_loader_pkg::data_type snap;
  logic [31:0] rng = 32'hA5BB;
  int n_errors = 0, comparisons = 0, w;
  cfg_link_if cfg_link_if_i ();
  cfg_prom_ctrl cfg_prom_ctrl_i (.sys_clk, .rst_n, .jtag_config_cmd,
    .core_power_good, .io_power_good, .parallel_variant,
    .revisioning_enable, .external_select_enable, .revision_choice_pins,
    .internal_revision_bits, .clock_output_enable, .active_revision,
    .link(cfg_link_if_i));
  cfg_target_end cfg_target_end_i (.sys_clk, .rst_n, .hold_init_low,
    .busy_request, .done_level, .clearing(), .ready_for_bitstream(),
    .link(cfg_link_if_i));
  cfg_link_checker cfg_link_checker_i (.sys_clk, .rst_n,
    .config_trigger_out_n(cfg_link_if_i.config_trigger_out_n),
    .reset_line_drive_low(cfg_link_if_i.reset_line_drive_low),
    .init_drive_low(cfg_link_if_i.init_drive_low),
    .reset_line_in(cfg_link_if_i.reset_line_in),
    .chain_enable_out_n(cfg_link_if_i.chain_enable_out_n),
    .chip_enable_n(cfg_link_if_i.chip_enable_n),
    .data_oe(cfg_link_if_i.data_oe), .busy(cfg_link_if_i.busy),
    .target_read_write_n(cfg_link_if_i.target_read_write_n),
    .target_chip_select_n(cfg_link_if_i.target_chip_select_n),
    .data_out(cfg_link_if_i.data_out));
  always #5 sys_clk = ~sys_clk;
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic cfg_loader_pkg::rev_type want(input logic en,
    input logic ext, input cfg_loader_pkg::rev_type p,
    input cfg_loader_pkg::rev_type b);
    return !en ? 2'h0 : (ext ? p : b);
  endfunction : want
  task automatic chk(input string what, input logic [7:0] e,
    input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic wait_line(input int lim);
    w = 0;
    while (cfg_link_if_i.reset_line_in !== 1'b1 && w < lim) begin
      tick(1);
      w++;
    end
    chk("reset line", 8'h01, cfg_link_if_i.reset_line_in);
  endtask : wait_line
  task automatic give_verdict;
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #300000;
    n_errors++;
    give_verdict();
  end
  initial begin
    tick(5);
    rst_n <= 1'b1;
    core_power_good <= 1'b1;
    tick(300);
    chk("io wait", 8'h00, cfg_link_if_i.reset_line_in);
    chk("chain", 8'h01, cfg_link_if_i.chain_enable_out_n);
    io_power_good <= 1'b1;
    tick(150);
    chk("early", 8'h00, cfg_link_if_i.reset_line_in);
    wait_line(120);
    core_power_good <= 1'b0;
    parallel_variant <= 1'b0;
    io_power_good <= 1'b0;
    tick(10);
    chk("brown-out", 8'h00, cfg_link_if_i.reset_line_in);
    core_power_good <= 1'b1;
    wait_line(260);
    chk("standby", 8'h00, cfg_link_if_i.data_oe);
    done_level <= 1'b0;
    tick(10);
    chk("enabled", 8'h01, cfg_link_if_i.data_oe);
    chk("clock source", 8'(cfg_link_if_i.prom_clock_output), 8'(cfg_link_if_i.target_config_clock));
    clock_output_enable <= 1'b0;
    tick(3);
    chk("clock off", 8'h00, cfg_link_if_i.prom_clock_oe);
    clock_output_enable <= 1'b1;
    tick(3);
    chk("clock on", 8'h01, cfg_link_if_i.prom_clock_oe);
    busy_request <= 1'b1;
    tick(6);
    snap = cfg_link_if_i.data_out;
    tick(30);
    chk("stalled", snap, cfg_link_if_i.data_out);
    busy_request <= 1'b0;
    tick(40);
    chk("running", 8'h01, cfg_link_if_i.data_out !== snap);
    hold_init_low <= 1'b1;
    tick(8);
    chk("monitor", 8'h00, cfg_link_if_i.data_oe);
    hold_init_low <= 1'b0;
    wait_line(10);
    for (int k = 0; k < 8; k++) begin
      rng = xs(rng);
      revisioning_enable <= (k > 1) ? rng[0] : k[0];
      external_select_enable <= rng[1];
      revision_choice_pins <= rng[3:2];
      internal_revision_bits <= rng[5:4];
      jtag_config_cmd <= 1'b1;
      w = 0;
      while (cfg_link_if_i.config_trigger_out_n !== 1'b0 && w < 20) begin
        tick(1);
        w++;
      end
      w = 0;
      while (cfg_link_if_i.config_trigger_out_n === 1'b0 && w < 99) begin
        if (w == 10) begin
          revision_choice_pins <= rng[7:6];
          internal_revision_bits <= rng[9:8];
          jtag_config_cmd <= 1'b0;
        end
        if (w == 15) begin
          jtag_config_cmd <= 1'b1;
        end
        tick(1);
        w++;
      end
      chk("width", 8'(`TRIG_CYCLES), 8'(w));
      rev_exp = want(revisioning_enable, external_select_enable,
        revision_choice_pins, internal_revision_bits);
      jtag_config_cmd <= 1'b0;
      tick(2);
      chk("revision", rev_exp, active_revision);
      w = 0;
      while (cfg_link_if_i.config_trigger_out_n === 1'b1 && w < 60) begin
        tick(1);
        w++;
      end
      chk("one pulse", 8'h01, cfg_link_if_i.config_trigger_out_n);
      wait_line(200);
    end
    give_verdict();
  end
endmodule : config_prom_start_and_reset_bench
`default_nettype wire
